// File: rtl/gst_pkg.sv
// Constants used by the 16-bit gated timer core; its prescaler takes none of them.
// Assumes an 8-bit register port with byte addresses 0 to 6.
package gst_pkg;
  // Register byte addresses.
  localparam logic [2:0] ADDR_COUNT_LO   = 3'h0;
  localparam logic [2:0] ADDR_COUNT_HI   = 3'h1;
  localparam logic [2:0] ADDR_TIMER_CTRL = 3'h2;
  localparam logic [2:0] ADDR_GATE_CTRL  = 3'h3;
  localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
  localparam logic [2:0] ADDR_IRQ_CLEAR  = 3'h5;
  localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h6;
  // Field positions in the timer control, gate control and interrupt registers.
  localparam int CTRL_RUN_BIT    = 0;
  localparam int CTRL_SYNC_DIS   = 2;
  localparam int CTRL_OSC_EN     = 3;
  localparam int CTRL_PRESC_LSB  = 4;
  localparam int CTRL_SRC_LSB    = 6;
  localparam int GATE_EN_BIT     = 7;
  localparam int IRQ_OVF_BIT     = 0;
  // Values after reset, and the largest count.
  localparam logic [7:0]  TIMER_CTRL_RESET = 8'h00;
  localparam logic [7:0]  GATE_CTRL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET      = 16'h0000;
  localparam logic [15:0] COUNT_MAX        = 16'hFFFF;
  // System clock cycles per instruction cycle.
  localparam int INSTR_CYCLES = 4;
  // Clock source codes.
  typedef enum logic [1:0] {
    GST_SRC_INSTR  = 2'b00,
    GST_SRC_SYS    = 2'b01,
    GST_SRC_EXT    = 2'b10,
    GST_SRC_CAPOSC = 2'b11
  } gst_src_t;
  // Counter-mode arming states.
  typedef enum logic {
    GST_ARM_WAIT  = 1'b0,
    GST_ARM_READY = 1'b1
  } gst_arm_t;
endpackage

// File: rtl/gst_prescaler.sv
// Prescaler that passes one of every 1, 2, 4 or 8 input ticks.
// Assumes tick_in is a one-cycle enable on clk.
`timescale 1ns/1ps
module gst_prescaler #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Control
  input  wire logic             clear,
  input  wire logic [1:0]       select,
  // Ticks
  input  wire logic             tick_in,
  output logic                  tick_out
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] mask;

  // Divide by two to the power select: all low select bits must be ones.
  assign mask     = WIDTH'((1 << select) - 1);
  assign tick_out = tick_in && ((cnt_reg & mask) == mask);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (clear) begin
      cnt_reg <= '0;
    end else if (tick_in) begin
      cnt_reg <= cnt_reg + WIDTH'(1);
    end
  end

  presc_clear_a: assert property (@(posedge clk) disable iff (reset)
    clear |=> cnt_reg == '0) else $error("prescaler not cleared");
  presc_div1_a: assert property (@(posedge clk) disable iff (reset)
    (select == 2'b00) |-> tick_out == tick_in) else $error("divide by one broken");
endmodule

// File: rtl/gst_timer.sv
// Top of the 16-bit gated timer/counter with its register port.
// Assumes pins are synchronous to clk and the gate logic drives count_enable.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module gst_timer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Register port
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Count sources and gate
  input  wire logic       external_count_pin,
  input  wire logic       cap_osc_in,
  input  wire logic       crystal_in_pin,
  input  wire logic       count_enable,
  // Power state
  input  wire logic       sleep,
  // Crystal amplifier drive
  output logic            crystal_out_pin_o,
  output logic            crystal_out_pin_oe,
  // Interrupt and wake
  output logic            irq,
  output logic            wake
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [15:0]        count_reg;
  logic [15:0]        count_next;
  logic [7:0]         timer_control_reg;
  logic [7:0]         gate_control_reg;
  logic               overflow_flag_reg;
  logic               irq_enable_reg;
  logic [1:0]         instr_div_reg;
  logic               ext_sync1_reg;
  logic               ext_sync2_reg;
  logic               ext_raw_reg;
  logic               ext_prev_reg;
  gst_pkg::gst_arm_t  arm_reg;

  logic               run_bit;
  logic               gate_enable;
  logic               osc_enable;
  logic               sync_disable;
  logic [1:0]         prescale_select;
  gst_pkg::gst_src_t  clock_source_select;

  assign run_bit             = timer_control_reg[gst_pkg::CTRL_RUN_BIT];
  assign sync_disable        = timer_control_reg[gst_pkg::CTRL_SYNC_DIS];
  assign osc_enable          = timer_control_reg[gst_pkg::CTRL_OSC_EN];
  assign prescale_select     = timer_control_reg[gst_pkg::CTRL_PRESC_LSB +: 2];
  assign clock_source_select =
    gst_pkg::gst_src_t'(timer_control_reg[gst_pkg::CTRL_SRC_LSB +: 2]);
  assign gate_enable         = gate_control_reg[gst_pkg::GATE_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Write decode.
  logic wr_lo;
  logic wr_hi;
  logic count_write;
  logic clear_ovf;

  assign wr_lo       = wr && (addr == gst_pkg::ADDR_COUNT_LO);
  assign wr_hi       = wr && (addr == gst_pkg::ADDR_COUNT_HI);
  assign count_write = wr_lo || wr_hi;
  assign clear_ovf   = wr && (addr == gst_pkg::ADDR_IRQ_CLEAR)
                       && wdata[gst_pkg::IRQ_OVF_BIT];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer_control_reg <= gst_pkg::TIMER_CTRL_RESET;
      gate_control_reg  <= gst_pkg::GATE_CTRL_RESET;
      irq_enable_reg    <= 1'b0;
    end else if (wr) begin
      if (addr == gst_pkg::ADDR_TIMER_CTRL) begin
        timer_control_reg <= wdata;
      end
      if (addr == gst_pkg::ADDR_GATE_CTRL) begin
        gate_control_reg <= wdata;
      end
      if (addr == gst_pkg::ADDR_IRQ_ENABLE) begin
        irq_enable_reg <= wdata[gst_pkg::IRQ_OVF_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction clock enable: one pulse every four system clocks.
  logic instr_tick;

  assign instr_tick = (instr_div_reg == 2'(gst_pkg::INSTR_CYCLES - 1));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      instr_div_reg <= 2'h0;
    end else begin
      instr_div_reg <= instr_div_reg + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External source: the pin, the crystal input or the sensing oscillator.
  logic ext_src;
  logic ext_level;
  logic ext_rise;
  logic ext_fall;
  logic ext_selected;

  assign ext_selected = (clock_source_select == gst_pkg::GST_SRC_EXT)
                        || (clock_source_select == gst_pkg::GST_SRC_CAPOSC);
  always_comb begin
    if (clock_source_select == gst_pkg::GST_SRC_CAPOSC) begin
      ext_src = cap_osc_in;
    end else if (osc_enable) begin
      ext_src = crystal_in_pin;
    end else begin
      ext_src = external_count_pin;
    end
  end

  // The synchronised path is one stage longer than the direct one, so a
  // mode change can drop or repeat one edge.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_raw_reg   <= 1'b0;
      ext_prev_reg  <= 1'b0;
    end else begin
      ext_sync1_reg <= ext_src;
      ext_sync2_reg <= ext_sync1_reg;
      ext_raw_reg   <= ext_src;
      ext_prev_reg  <= ext_level;
    end
  end

  assign ext_level = sync_disable ? ext_raw_reg : ext_sync2_reg;
  assign ext_rise  = ext_level && !ext_prev_reg;
  assign ext_fall  = !ext_level && ext_prev_reg;

  // Counter mode: a falling edge must be seen before the first counted rise.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arm_reg <= gst_pkg::GST_ARM_WAIT;
    end else if (count_write || !run_bit) begin
      arm_reg <= gst_pkg::GST_ARM_WAIT;
    end else begin
      unique case (arm_reg)
        gst_pkg::GST_ARM_WAIT: begin
          if (ext_fall) begin
            arm_reg <= gst_pkg::GST_ARM_READY;
          end
        end
        gst_pkg::GST_ARM_READY: begin
          arm_reg <= gst_pkg::GST_ARM_READY;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count enable and source ticks.
  logic running;
  logic awake_ok;
  logic src_tick;
  logic presc_tick;

  // In sleep the core clocks stop; only unsynchronised external counting runs.
  assign awake_ok = !sleep || (sync_disable && ext_selected);
  assign running  = run_bit && (!gate_enable || count_enable)
                    && awake_ok;

  always_comb begin
    unique case (clock_source_select)
      gst_pkg::GST_SRC_SYS:   src_tick = 1'b1;
      gst_pkg::GST_SRC_INSTR: src_tick = instr_tick;
      default:                src_tick = ext_rise && (arm_reg == gst_pkg::GST_ARM_READY);
    endcase
  end

  gst_prescaler #(
    .WIDTH (3)
  ) u_prescaler (
    .clk      (clk),
    .reset    (reset),
    .clear    (count_write),
    .select   (prescale_select),
    .tick_in  (src_tick && running),
    .tick_out (presc_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter. A byte write takes precedence over a coincident increment.
  logic overflow_event;

  assign overflow_event = presc_tick && !count_write && (count_reg == gst_pkg::COUNT_MAX);

  always_comb begin
    count_next = count_reg;
    if (count_write) begin
      if (wr_lo) begin
        count_next[7:0] = wdata;
      end
      if (wr_hi) begin
        count_next[15:8] = wdata;
      end
    end else if (presc_tick) begin
      count_next = count_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= gst_pkg::COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flag: a rollover in the same cycle as a clear keeps the flag set.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      overflow_flag_reg <= 1'b0;
    end else if (overflow_event) begin
      overflow_flag_reg <= 1'b1;
    end else if (clear_ovf) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq  <= 1'b0;
      wake <= 1'b0;
    end else begin
      irq  <= overflow_flag_reg && irq_enable_reg;
      wake <= overflow_flag_reg && irq_enable_reg && sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crystal amplifier: inverting drive while the oscillator is enabled.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      crystal_out_pin_o  <= 1'b0;
      crystal_out_pin_oe <= 1'b0;
    end else begin
      crystal_out_pin_o  <= osc_enable && !crystal_in_pin;
      crystal_out_pin_oe <= osc_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stand in the cycle after the strobe, otherwise zero.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        gst_pkg::ADDR_COUNT_LO:   rdata <= count_reg[7:0];
        gst_pkg::ADDR_COUNT_HI:   rdata <= count_reg[15:8];
        gst_pkg::ADDR_TIMER_CTRL: rdata <= timer_control_reg;
        gst_pkg::ADDR_GATE_CTRL:  rdata <= gate_control_reg;
        gst_pkg::ADDR_IRQ_STATUS: rdata <= {7'h00, overflow_flag_reg};
        gst_pkg::ADDR_IRQ_ENABLE: rdata <= {7'h00, irq_enable_reg};
        default:                  rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  low_byte_write_a: assert property (
    wr_lo |=> count_reg[7:0] == $past(wdata)) else $error("low byte write lost");
  high_byte_write_a: assert property (
    wr_hi |=> count_reg[15:8] == $past(wdata)) else $error("high byte write lost");
  high_write_keep_a: assert property (
    (wr_hi && !wr_lo) |=> count_reg[7:0] == $past(count_reg[7:0]))
    else $error("low byte moved on a high byte write");
  run_off_hold_a: assert property (
    (!run_bit && !count_write) |=> $stable(count_reg)) else $error("counted while off");
  gate_closed_hold_a: assert property (
    (gate_enable && !count_enable && !count_write) |=> $stable(count_reg))
    else $error("counted with gate closed");
  sys_clock_rate_a: assert property (
    (clock_source_select == gst_pkg::GST_SRC_SYS && prescale_select == 2'b00
     && run_bit && !gate_enable && !sleep && !count_write)
    |=> count_reg == $past(count_reg) + 16'h0001) else $error("system clock rate wrong");
  instr_clock_rate_a: assert property (
    (clock_source_select == gst_pkg::GST_SRC_INSTR && prescale_select == 2'b00
     && run_bit && !gate_enable && !sleep && !count_write && !instr_tick)
    |=> $stable(count_reg)) else $error("instruction clock counted early");
  instr_tick_gap_a: assert property (
    instr_tick |=> !instr_tick) else $error("instruction tick too long");
  arm_after_write_a: assert property (
    count_write |=> arm_reg == gst_pkg::GST_ARM_WAIT) else $error("arm kept on write");
  unarmed_hold_a: assert property (
    (ext_selected && arm_reg == gst_pkg::GST_ARM_WAIT && !count_write)
    |=> $stable(count_reg)) else $error("counted before a falling edge");
  sleep_sync_hold_a: assert property (
    (sleep && !sync_disable && !count_write) |=> $stable(count_reg))
    else $error("synchronous count in sleep");
  sleep_int_hold_a: assert property (
    (sleep && !ext_selected && !count_write) |=> $stable(count_reg))
    else $error("internal source counted in sleep");
  wake_awake_low_a: assert property (
    !sleep |=> !wake) else $error("wake raised outside sleep");
  wake_needs_enable_a: assert property (
    !irq_enable_reg |=> !wake) else $error("wake raised while disabled");
  ovf_flag_set_a: assert property (
    overflow_event |=> overflow_flag_reg && count_reg == 16'h0000)
    else $error("rollover without flag");
  ovf_flag_hold_a: assert property (
    (overflow_flag_reg && !clear_ovf) |=> overflow_flag_reg) else $error("flag lost");
  ovf_flag_clear_a: assert property (
    (clear_ovf && !overflow_event) |=> !overflow_flag_reg) else $error("flag not cleared");
  osc_drive_a: assert property (
    osc_enable |-> ##1 crystal_out_pin_oe ##1 crystal_out_pin_oe || !$past(osc_enable))
    else $error("oscillator drive off");
  osc_off_a: assert property (
    !osc_enable |=> !crystal_out_pin_oe) else $error("oscillator drive left on");
  irq_follow_a: assert property (
    (overflow_flag_reg && irq_enable_reg) |=> irq) else $error("interrupt not raised");
  read_idle_a: assert property (
    !rd |=> rdata == 8'h00) else $error("read data outside a read cycle");

  // The main scenarios: rollover, sleep counting, external counting and prescaling.
  overflow_seen_c: cover property (overflow_event ##1 irq);
  async_sleep_count_c: cover property (sleep && sync_disable && presc_tick);
  ext_count_c: cover property (
    clock_source_select == gst_pkg::GST_SRC_EXT && arm_reg == gst_pkg::GST_ARM_READY
    && presc_tick);
  presc_eight_c: cover property (prescale_select == 2'b11 && presc_tick);
  unarmed_rise_c: cover property (
    ext_rise && arm_reg == gst_pkg::GST_ARM_WAIT && running);
endmodule

// File: verification/gst_count_source.sv
// Far-side count sources: external pin, sensing oscillator and crystal input.
// Assumes the bench calls send_pulses; every line rests low between bursts.
`timescale 1ns/1ps
module gst_count_source (
  // Clock
  input  wire logic clk,
  // Source lines
  output logic      ext_pin,
  output logic      cap_osc,
  output logic      xtal_in
);
  logic [2:0] lvl;

  assign ext_pin = lvl[0];
  assign cap_osc = lvl[1];
  assign xtal_in = lvl[2];

  initial lvl = 3'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Bursts start from low, so the first rise comes before any fall.
  task automatic send_pulses(input int sel, input int n, input int half);
    for (int i = 0; i < 2 * n; i++) begin
      repeat (half) @(posedge clk);
      lvl[sel] <= ~lvl[sel];
    end
    repeat (half) @(posedge clk);
  endtask
endmodule

// File: verification/test_gst_timer.sv
// Self-checking bench for the gated 16-bit timer core.
// Assumes a 40 MHz clock and count sources from gst_count_source.
`timescale 1ns/1ps
module test_gst_timer;
  logic       clk, reset, wr, rd, count_enable, sleep;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, v;
  logic       ext_pin, cap_osc, xtal_in, xo, xoe, irq, wake;
  int         n_fail, check_count;

  gst_timer i_dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .external_count_pin(ext_pin), .cap_osc_in(cap_osc), .crystal_in_pin(xtal_in),
    .count_enable(count_enable), .sleep(sleep), .crystal_out_pin_o(xo),
    .crystal_out_pin_oe(xoe), .irq(irq), .wake(wake));
  gst_count_source i_src (.clk(clk), .ext_pin(ext_pin), .cap_osc(cap_osc), .xtal_in(xtal_in));

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Low-byte advance across exactly 64 clocks between two live reads.
  task automatic advance(output logic [7:0] d);
    logic [7:0] a;
    rd_reg(3'h0, a);
    repeat (62) @(posedge clk);
    rd_reg(3'h0, d);
    d = d - a;
  endtask

  task automatic wait_irq(input logic lvl);
    for (int k = 0; k < 20 && irq !== lvl; k++) begin
      @(posedge clk);
      #1;
    end
    check("irq", {15'h0000, irq}, {15'h0000, lvl});
    if (irq !== lvl) print_verdict();
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    wr_reg(3'h7, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      rd_reg(a[2:0], v);
      check("reset read", v, 16'h0000);
    end
  endtask

  task automatic t_bytes();
    wr_reg(3'h1, 8'hC3);
    wr_reg(3'h0, 8'h5A);
    wr_reg(3'h2, 8'hA6);
    rd_reg(3'h1, v);
    check("count high", v, 16'h00C3);
    rd_reg(3'h0, v);
    check("count low", v, 16'h005A);
    rd_reg(3'h2, v);
    check("control", v, 16'h00A6);
  endtask

  task automatic t_rates();
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        wr_reg(3'h2, {s[1:0], p[1:0], 4'h1});
        advance(v);
        check("rate", v, ((s == 1) ? 16'h0040 : 16'h0010) >> p);
      end
    end
  endtask

  task automatic t_gate();
    for (int i = 0; i < 5; i++) begin
      wr_reg(3'h3, {i[1], 7'h00});
      count_enable <= i[0];
      wr_reg(3'h2, (i == 0) ? 8'h40 : 8'h41);
      advance(v);
      check("gated rate", v, (i == 0 || i == 2) ? 16'h0000 : 16'h0040);
    end
    wr_reg(3'h3, 8'h00);
  endtask

  // Each count write restarts the divide-by-8 prescaler at any phase.
  task automatic t_presc_clear();
    wr_reg(3'h2, 8'h71);
    for (int i = 0; i < 8; i++) begin
      repeat (i) @(posedge clk);
      wr_reg(3'h0, 8'h00);
      repeat (11) @(posedge clk);
      rd_reg(3'h0, v);
      check("prescaled low", v, 16'h0001);
    end
  endtask

  task automatic t_overflow();
    wr_reg(3'h2, 8'h40);
    wr_reg(3'h1, 8'hFF);
    wr_reg(3'h0, 8'hFC);
    wr_reg(3'h6, 8'h01);
    wr_reg(3'h2, 8'h41);
    wait_irq(1'b1);
    rd_reg(3'h1, v);
    check("high after rollover", v, 16'h0000);
    wr_reg(3'h4, 8'h00);
    rd_reg(3'h4, v);
    check("sticky flag", v, 16'h0001);
    wr_reg(3'h6, 8'h00);
    wait_irq(1'b0);
    wr_reg(3'h6, 8'h01);
    wait_irq(1'b1);
    wr_reg(3'h5, 8'h01);
    wait_irq(1'b0);
    rd_reg(3'h4, v);
    check("cleared flag", v, 16'h0000);
  endtask

  task automatic t_external();
    logic [7:0] ctl [5] = '{8'h81, 8'h89, 8'hC1, 8'h85, 8'hCD};
    int         sel [5] = '{0, 2, 1, 0, 1};
    for (int i = 0; i < 5; i++) begin
      wr_reg(3'h2, ctl[i]);
      wr_reg(3'h0, 8'h00);
      i_src.send_pulses(sel[i], 5, 3);
      rd_reg(3'h0, v);
      check("first burst", v, 16'h0004);
      i_src.send_pulses(sel[i], 3, 6);
      rd_reg(3'h0, v);
      check("second burst", v, 16'h0007);
      check("osc enable", {15'h0000, xoe}, {15'h0000, ctl[i][3]});
      check("osc drive", {15'h0000, xo}, {15'h0000, ctl[i][3]});
    end
  endtask

  task automatic t_sleep();
    wr_reg(3'h2, 8'h8C);
    wr_reg(3'h1, 8'hFF);
    wr_reg(3'h0, 8'hFE);
    wr_reg(3'h6, 8'h01);
    wr_reg(3'h2, 8'h8D);
    sleep <= 1'b1;
    i_src.send_pulses(2, 3, 3);
    check("wake", {15'h0000, wake}, 16'h0001);
    check("osc in sleep", {15'h0000, xoe}, 16'h0001);
    sleep <= 1'b0;
    wr_reg(3'h5, 8'h01);
    wr_reg(3'h2, 8'h89);
    wr_reg(3'h0, 8'h00);
    sleep <= 1'b1;
    i_src.send_pulses(2, 3, 3);
    sleep <= 1'b0;
    rd_reg(3'h0, v);
    check("synced in sleep", v, 16'h0000);
  endtask

  // Start-up wait: preset FC00h with the counter stopped, flag after 1024 counted rises.
  task automatic t_osc_start();
    wr_reg(3'h2, 8'h8C);
    wr_reg(3'h5, 8'h01);
    wr_reg(3'h1, 8'hFC);
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h2, 8'h8D);
    i_src.send_pulses(2, 1024, 1);
    rd_reg(3'h4, v);
    check("flag before 1024", v, 16'h0000);
    rd_reg(3'h0, v);
    check("low before 1024", v, 16'h00FF);
    i_src.send_pulses(2, 1, 1);
    rd_reg(3'h4, v);
    check("flag at 1024", v, 16'h0001);
    wr_reg(3'h5, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk          = 1'b0;
    reset        = 1'b1;
    wr           = 1'b0;
    rd           = 1'b0;
    addr         = 3'h0;
    wdata        = 8'h00;
    count_enable = 1'b0;
    sleep        = 1'b0;
    n_fail       = 0;
    check_count  = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset_values();
    t_bytes();
    t_rates();
    t_gate();
    t_presc_clear();
    t_overflow();
    t_external();
    t_sleep();
    t_osc_start();
    print_verdict();
  end
endmodule
